// ---- tia_chan_cfg.sv ----
// Per-channel configuration registers of a three-channel optical receiver amplifier,
// channels 1 to 3, behind the register port of the two-wire protocol engine.
// Assumes the engine hands over one byte per transfer on reg_wr_en, and that the
// global register supplies the broadcast and soft reset controls as plain levels.
// Summary of operation
// - Bits 7:4 first register: bandwidth trim
// - Bits 3:0 first register: output swing code
// - Bit 7 second register: channel power-down
// - Bit 6 second register: output buffer off
// - Bits 5:4 second register: gain step
// - Bits 3:0 second register: sign-magnitude threshold shift
// - Pairs at 01/02, 07/08, 0D/0E
// - All fields read/write, reset to zero
// - Channels 2,3 share layout; 08h is channel 2
// - Broadcast bit copies a write to every channel
// - Global reset bit clears all channel registers
`timescale 1ns/1ps
`default_nettype none
`include "tia_chan_cfg_regs.svh"

module tia_chan_cfg (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port from the serial engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wr_data,
    input  wire logic        reg_rd_en,
    output var  logic [7:0]  reg_rd_data,
    output var  logic        reg_rd_hit,
    // Global controls
    input  wire logic        broadcast_write,
    input  wire logic        soft_reset,
    // Per-channel fields, channel 1 in the low slice
    output var  logic [11:0] bandwidth_trim,
    output var  logic [11:0] output_swing_code,
    output var  logic [2:0]  channel_powerdown,
    output var  logic [2:0]  output_buffer_off,
    output var  logic [5:0]  gain_step,
    output var  logic [11:0] decision_offset
);

    tia_chan_cfg_pkg::tia_byte_type bw_swing_r [`TIA_NUM_CHAN];
    tia_chan_cfg_pkg::tia_byte_type ctrl_r     [`TIA_NUM_CHAN];
    tia_chan_cfg_pkg::tia_decode_type dec;

    function automatic tia_chan_cfg_pkg::tia_decode_type decode_addr(input logic [7:0] a);
        tia_chan_cfg_pkg::tia_decode_type d;
        d = '0;
        case (a)
            `TIA_ADDR_CH1_BW_SWING: d = '{1'b1, 2'd0, 1'b0};
            `TIA_ADDR_CH1_CTRL:     d = '{1'b1, 2'd0, 1'b1};
            `TIA_ADDR_CH2_BW_SWING: d = '{1'b1, 2'd1, 1'b0};
            `TIA_ADDR_CH2_CTRL:     d = '{1'b1, 2'd1, 1'b1};
            `TIA_ADDR_CH3_BW_SWING: d = '{1'b1, 2'd2, 1'b0};
            `TIA_ADDR_CH3_CTRL:     d = '{1'b1, 2'd2, 1'b1};
            default:                d = '0;
        endcase
        return d;
    endfunction : decode_addr

    assign dec = decode_addr(reg_addr);

    // Soft reset outranks a write in the same cycle, so a reset byte is never half undone.
    // Codes marked unsupported are stored as written; filtering belongs to the analog side.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `TIA_NUM_CHAN; i++) begin
                bw_swing_r[i] <= `TIA_REG_RESET_VAL;
                ctrl_r[i]     <= `TIA_REG_RESET_VAL;
            end
        end else if (soft_reset) begin
            for (int i = 0; i < `TIA_NUM_CHAN; i++) begin
                bw_swing_r[i] <= `TIA_REG_RESET_VAL;
                ctrl_r[i]     <= `TIA_REG_RESET_VAL;
            end
        end else if (reg_wr_en && dec.hit) begin
            for (int i = 0; i < `TIA_NUM_CHAN; i++) begin
                if (broadcast_write || dec.chan == 2'(i)) begin
                    if (dec.sel_ctrl) begin
                        ctrl_r[i] <= reg_wr_data;
                    end else begin
                        bw_swing_r[i] <= reg_wr_data;
                    end
                end
            end
        end
    end

    // Read data is registered; unmapped addresses return zero with hit low.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data <= `TIA_READ_UNMAPPED;
            reg_rd_hit  <= 1'b0;
        end else if (reg_rd_en) begin
            reg_rd_hit <= dec.hit;
            if (!dec.hit) begin
                reg_rd_data <= `TIA_READ_UNMAPPED;
            end else if (dec.sel_ctrl) begin
                reg_rd_data <= ctrl_r[dec.chan];
            end else begin
                reg_rd_data <= bw_swing_r[dec.chan];
            end
        end
    end

    // Field outputs are wired straight from the register bits.
    always_comb begin
        for (int i = 0; i < `TIA_NUM_CHAN; i++) begin
            bandwidth_trim[4*i +: 4]    = bw_swing_r[i][`TIA_BW_TRIM_MSB:`TIA_BW_TRIM_LSB];
            output_swing_code[4*i +: 4] = bw_swing_r[i][`TIA_SWING_MSB:`TIA_SWING_LSB];
            channel_powerdown[i]        = ctrl_r[i][`TIA_PWRDN_BIT];
            output_buffer_off[i]        = ctrl_r[i][`TIA_BUF_OFF_BIT];
            gain_step[2*i +: 2]         = ctrl_r[i][`TIA_GAIN_MSB:`TIA_GAIN_LSB];
            decision_offset[4*i +: 4]   = ctrl_r[i][`TIA_OFFSET_MSB:`TIA_OFFSET_LSB];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence seq_plain_wr(logic [7:0] a);
        reg_wr_en && !soft_reset && !broadcast_write && reg_addr == a;
    endsequence

    sequence seq_bcast_wr(logic [7:0] a);
        reg_wr_en && !soft_reset && broadcast_write && reg_addr == a;
    endsequence

    sequence seq_read_at(logic [7:0] a);
        reg_rd_en && !reg_wr_en && !soft_reset && reg_addr == a;
    endsequence

    // The mapped set is spelled out again rather than taken from decode_addr,
    // so a slip in the decoder cannot hide behind the check that guards it.
    sequence seq_rd_unmapped;
        reg_rd_en
        && !(reg_addr inside {8'h01, 8'h02, 8'h07, 8'h08, 8'h0d, 8'h0e});
    endsequence

    sequence seq_wr_unmapped;
        reg_wr_en && !soft_reset
        && !(reg_addr inside {8'h01, 8'h02, 8'h07, 8'h08, 8'h0d, 8'h0e});
    endsequence

    chk_soft_reset_clears: assert property (
        soft_reset |=> (ctrl_r[0] == 8'h00 && ctrl_r[1] == 8'h00 && ctrl_r[2] == 8'h00
                        && bw_swing_r[0] == 8'h00 && bw_swing_r[1] == 8'h00
                        && bw_swing_r[2] == 8'h00))
        else $error("soft reset left a channel register nonzero");

    chk_ch1_bw_trim: assert property (
        seq_plain_wr(8'h01) |=> bandwidth_trim[3:0] == $past(reg_wr_data[7:4]))
        else $error("channel 1 bandwidth trim not taken");

    chk_ch3_swing_code: assert property (
        seq_plain_wr(8'h0d) |=> output_swing_code[11:8] == $past(reg_wr_data[3:0]))
        else $error("channel 3 swing code not taken");

    chk_ch2_pwrdn_addr: assert property (
        seq_plain_wr(8'h08) |=> channel_powerdown[1] == $past(reg_wr_data[7])
                                && output_buffer_off[1] == $past(reg_wr_data[6]))
        else $error("register 08h did not steer channel 2");

    chk_ch1_gain_ctrl: assert property (
        seq_plain_wr(8'h02) |=> gain_step[1:0] == $past(reg_wr_data[5:4])
                                && channel_powerdown[0] == $past(reg_wr_data[7]))
        else $error("channel 1 gain or power-down wrong");

    chk_ch3_offset_buf: assert property (
        seq_plain_wr(8'h0e) |=> decision_offset[11:8] == $past(reg_wr_data[3:0])
                                && output_buffer_off[2] == $past(reg_wr_data[6]))
        else $error("channel 3 offset or buffer bit wrong");

    chk_bcast_all_chan: assert property (
        seq_bcast_wr(8'h07) |=> bw_swing_r[0] == $past(reg_wr_data)
                                && bw_swing_r[1] == $past(reg_wr_data)
                                && bw_swing_r[2] == $past(reg_wr_data))
        else $error("broadcast write missed a channel");

    chk_single_chan_only: assert property (
        seq_plain_wr(8'h08) |=> $stable(ctrl_r[0]) && $stable(ctrl_r[2]))
        else $error("plain write disturbed another channel");

    // The engine needs two cycles per transfer, so the earliest read lands two edges later.
    chk_readback_exact: assert property (
        seq_plain_wr(8'h02) ##1 (!soft_reset && !reg_wr_en) ##1 seq_read_at(8'h02)
        |=> reg_rd_hit && reg_rd_data == $past(reg_wr_data, 3))
        else $error("read back differs from written byte");

    chk_unmapped_zero: assert property (
        seq_rd_unmapped |=> !reg_rd_hit && reg_rd_data == 8'h00)
        else $error("unmapped read not zero");

    chk_wr_unmapped_ignored: assert property (
        seq_wr_unmapped |=> $stable(bw_swing_r[0]) && $stable(bw_swing_r[1])
                            && $stable(bw_swing_r[2]) && $stable(ctrl_r[0])
                            && $stable(ctrl_r[1]) && $stable(ctrl_r[2]))
        else $error("write to an unmapped address changed a channel register");

    // Read data is only refreshed by a read strobe, so the engine may pick it up late.
    chk_rd_data_holds: assert property (
        !reg_rd_en |=> $stable(reg_rd_data) && $stable(reg_rd_hit))
        else $error("read data moved without a read strobe");

    chk_bcast_ctrl_all: assert property (
        seq_bcast_wr(8'h08) |=> ctrl_r[0] == $past(reg_wr_data)
                                && ctrl_r[1] == $past(reg_wr_data)
                                && ctrl_r[2] == $past(reg_wr_data))
        else $error("broadcast control write missed a channel");

    chk_ch2_bw_swing: assert property (
        seq_plain_wr(8'h07) |=> bandwidth_trim[7:4] == $past(reg_wr_data[7:4])
                                && output_swing_code[7:4] == $past(reg_wr_data[3:0]))
        else $error("register 07h did not steer channel 2");

    chk_ch1_offset_buf: assert property (
        seq_plain_wr(8'h02) |=> decision_offset[3:0] == $past(reg_wr_data[3:0])
                                && output_buffer_off[0] == $past(reg_wr_data[6]))
        else $error("channel 1 offset or buffer bit wrong");

endmodule : tia_chan_cfg

`default_nettype wire

// ---- tia_chan_cfg_regs.svh ----
// Register offsets, field positions and reset values of the per-channel config bank.
// Assumes the includer wants plain `define macros; no code lives here.
`ifndef TIA_CHAN_CFG_REGS_SVH
`define TIA_CHAN_CFG_REGS_SVH

`define TIA_NUM_CHAN          3
`define TIA_ADDR_CH1_BW_SWING 8'h01
`define TIA_ADDR_CH1_CTRL     8'h02
`define TIA_ADDR_CH2_BW_SWING 8'h07
`define TIA_ADDR_CH2_CTRL     8'h08
`define TIA_ADDR_CH3_BW_SWING 8'h0d
`define TIA_ADDR_CH3_CTRL     8'h0e
`define TIA_REG_RESET_VAL     8'h00
`define TIA_READ_UNMAPPED     8'h00

// First register of a pair.
`define TIA_BW_TRIM_MSB       7
`define TIA_BW_TRIM_LSB       4
`define TIA_SWING_MSB         3
`define TIA_SWING_LSB         0

// Second register of a pair.
`define TIA_PWRDN_BIT         7
`define TIA_BUF_OFF_BIT       6
`define TIA_GAIN_MSB          5
`define TIA_GAIN_LSB          4
`define TIA_OFFSET_MSB        3
`define TIA_OFFSET_LSB        0
`define TIA_OFFSET_SIGN_BIT   3

`endif

// ---- tia_chan_cfg_pkg.sv ----
// Types shared by the per-channel configuration bank.
// Assumes the constants come from tia_chan_cfg_regs.svh.
package tia_chan_cfg_pkg;
    typedef logic [7:0] tia_byte_type;
    typedef logic [1:0] tia_chan_type;
    // Decoded register address: hit flag, channel index, second-register select.
    typedef struct packed {
        logic         hit;
        tia_chan_type chan;
        logic         sel_ctrl;
    } tia_decode_type;
endpackage : tia_chan_cfg_pkg

// ---- tia_host_model.sv ----
// Behavioural serial engine model that drives the register port of the channel bank.
// Assumes the bank samples strobes on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tia_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port towards the bank
    output var  logic [7:0] reg_addr = 8'h00,
    output var  logic       reg_wr_en = 1'b0,
    output var  logic [7:0] reg_wr_data = 8'h00,
    output var  logic       reg_rd_en = 1'b0
);
    // One register byte per transfer, and the strobe drops between transfers.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= wr;
        reg_rd_en   <= !wr;
        @(posedge clk_sys);
        reg_wr_en   <= 1'b0;
        reg_rd_en   <= 1'b0;
        // Released lines show the inverse, so a stale byte never looks live.
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask : xfer
endmodule : tia_host_model
`default_nettype wire

// ---- tia_chan_cfg_tb.sv ----
// Self-checking testbench of the channel configuration bank.
// Assumes one-cycle read latency and field outputs that follow a write at once.
`timescale 1ns/1ps
`default_nettype none
`include "tia_chan_cfg_regs.svh"
module tia_chan_cfg_tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        broadcast_write = 1'b0;
    logic        soft_reset = 1'b0;
    logic        rd_seen = 1'b0;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data;
    logic        reg_wr_en, reg_rd_en, reg_rd_hit;
    logic [11:0] bandwidth_trim, output_swing_code, decision_offset;
    logic [2:0]  channel_powerdown, output_buffer_off;
    logic [5:0]  gain_step;
    logic [7:0]  adr [6] = '{`TIA_ADDR_CH1_BW_SWING, `TIA_ADDR_CH1_CTRL, `TIA_ADDR_CH2_BW_SWING,
                             `TIA_ADDR_CH2_CTRL, `TIA_ADDR_CH3_BW_SWING, `TIA_ADDR_CH3_CTRL};
    logic [7:0]  m [6] = '{default: 8'h00};
    logic [8:0]  q [$];
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    always #12.5 clk_sys = ~clk_sys;

    tia_host_model tia_host_model_i (.clk_sys, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en);
    tia_chan_cfg tia_chan_cfg_i (.clk_sys, .reset_n, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data, .reg_rd_hit, .broadcast_write, .soft_reset, .bandwidth_trim,
        .output_swing_code, .channel_powerdown, .output_buffer_off, .gain_step, .decision_offset);

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Expected field outputs, worked out from the register image m.
    function automatic logic [47:0] fields();
        logic [11:0] bw, sw, dc;
        logic [2:0]  pd, bo;
        logic [5:0]  g;
        for (int c = 0; c < 3; c++) begin
            {bw[4*c+:4], sw[4*c+:4]} = m[2*c];
            {pd[c], bo[c], g[2*c+:2], dc[4*c+:4]} = m[2*c+1];
        end
        return {bw, sw, pd, bo, g, dc};
    endfunction : fields

    task automatic fchk();
        @(negedge clk_sys);
        chk({bandwidth_trim, output_swing_code, channel_powerdown, output_buffer_off,
             gain_step, decision_offset}, fields());
    endtask : fchk

    task automatic rd_all();
        for (int i = 0; i < 6; i++) begin
            q.push_back({1'b1, m[i]});
            tia_host_model_i.xfer(1'b0, adr[i], 8'h00);
        end
        q.push_back(9'h000);
        tia_host_model_i.xfer(1'b0, 8'h03, 8'h00);
        fchk();
    endtask : rd_all

    // The monitor takes the oldest note whenever read data appears.
    always @(posedge clk_sys) begin
        rd_seen <= reg_rd_en;
        cyc++;
        if (cyc > 2000) begin
            bad_count++;
            summarize();
        end
    end
    always @(negedge clk_sys) if (rd_seen) chk({reg_rd_hit, reg_rd_data}, q.pop_front());

    initial begin
        void'($urandom(32'h0000_011c));
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_all();
        // Random bytes first, then a byte made of codes that must not be used.
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 6; i++) begin
                m[i] = (k == 0) ? 8'($urandom) : 8'h18;
                tia_host_model_i.xfer(1'b1, adr[i], m[i]);
                fchk();
                // Read straight back, so a write and its read sit two edges apart.
                q.push_back({1'b1, m[i]});
                tia_host_model_i.xfer(1'b0, adr[i], 8'h00);
            end
            rd_all();
        end
        // A write to a hole in the map must leave every field alone.
        tia_host_model_i.xfer(1'b1, 8'h03, 8'hff);
        fchk();
        // Reset in mid-run: every register must come back as zero.
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        m = '{default: 8'h00};
        rd_all();
        @(posedge clk_sys);
        broadcast_write <= 1'b1;
        tia_host_model_i.xfer(1'b1, 8'h08, 8'hc5);
        tia_host_model_i.xfer(1'b1, 8'h07, 8'ha3);
        m = '{8'ha3, 8'hc5, 8'ha3, 8'hc5, 8'ha3, 8'hc5};
        broadcast_write <= 1'b0;
        tia_host_model_i.xfer(1'b1, 8'h08, 8'h6e);
        m[3] = 8'h6e;
        rd_all();
        // Soft reset held over a write: the reset wins and the byte is lost.
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        tia_host_model_i.xfer(1'b1, 8'h0e, 8'h5a);
        soft_reset <= 1'b0;
        m = '{default: 8'h00};
        rd_all();
        repeat (2) @(posedge clk_sys);
        summarize();
    end
endmodule : tia_chan_cfg_tb
`default_nettype wire
